/* File: pkg/gpio_expander_regs.svh */
// register offsets, reset values and sizes of the pin-side expander logic
// assumes inclusion by the top module only; defines nothing else
`ifndef GPIO_EXPANDER_REGS_SVH
`define GPIO_EXPANDER_REGS_SVH
// port, pin and debouncer counts, timebase pin
`define GX_NPORT 3
`define GX_NPIN 24
`define GX_NDB 16
`define GX_TIMEBASE_BIT 16
// register groups, addr[7:2] selects the group, addr[1:0] the port
`define GX_GRP_INPUT 6'h00
`define GX_GRP_OUTPUT 6'h01
`define GX_GRP_CONFIG 6'h02
`define GX_GRP_PULL_EN 6'h03
`define GX_GRP_PULL_SEL 6'h04
`define GX_GRP_LATCH 6'h05
// debounce registers
`define GX_DB_EN0_ADDR 8'h6D
`define GX_DB_EN1_ADDR 8'h6E
`define GX_DB_CNT_ADDR 8'h6F
// reset values
`define GX_OUTPUT_RST 8'hFF
`define GX_CONFIG_RST 8'hFF
`define GX_PULL_EN_RST 8'h00
`define GX_PULL_SEL_RST 8'hFF
`define GX_LATCH_RST 8'h00
`define GX_DB_EN_RST 8'h00
`define GX_DB_CNT_RST 8'h00
`endif

/* File: pkg/gpio_expander_pkg.sv */
// types shared by the expander pin logic
// assumes the offsets live in gpio_expander_regs.svh
package gpio_expander_pkg;
   // register request from the serial slave, same clock
   typedef struct packed {
      logic wr;
      logic rd;
      logic rd_ack;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_type;
   // per-pin pad controls
   typedef struct packed {
      logic [23:0] drive;
      logic [23:0] oe;
      logic [23:0] pull_up;
      logic [23:0] pull_dn;
      logic [23:0] in_buf_en;
   } pin_drive_type;
endpackage

/* File: verilog/gpio_expander_port.sv */
// pin-side logic of a serial-controlled gpio expander: pads, change
// interrupt with latch mode, and switch debouncers on ports 0 and 1
// assumes the serial slave on ref_clk delivers reg_req strobes, and
// that rst already merges power-on reset and the reset pin
// Functional notes
// - input pin: both drivers off
// - output pin driven from output register
// - pulls follow enable and direction select
// - output pin disables its input buffer
// - power-on reset loads all defaults
// - reset forces defaults, blocks register access
// - interrupt while input differs from register
// - any edge on input raises interrupt
// - unlatched: clear on return or read
// - output pins never interrupt
// - output-to-input switch may falsely interrupt
// - latched: hold state, clear only on read
// - read clear at acknowledge bit
// - changes after clear signalled again
// - debouncer per pin on ports 0, 1
// - output holds until input stable period
// - input edge restarts qualification counter
// - stable period clocks output flip-flop
// - period is timebase period times count
// - shared timebase and count, independent counters
// - debounce only on enabled inputs with timebase
// - count ten at 1 MHz gives 10 us
`timescale 1ns/1ps
`include "gpio_expander_regs.svh"
module gpio_expander_port (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   // register access from the serial slave
   input wire gpio_expander_pkg::reg_req_type reg_req,
   output logic [7:0] reg_rdata,
   // pads
   input wire logic [23:0] pin_in,
   output gpio_expander_pkg::pin_drive_type pin_drv,
   // open-drain interrupt, active low
   output logic int_n_out,
   output logic int_n_oe
);
   logic [23:0] out_q, cfg_q, pen_q, psel_q, lat_q;
   logic [15:0] db_en_q;
   logic [7:0] db_cnt_q;
   logic [23:0] sync1_q, sync2_q;
   logic [23:0] snap_q, latv_q, latf_q;
   logic [7:0] rdata_q;
   gpio_expander_pkg::pin_drive_type drv_q;
   logic int_oe_q, int_out_q;
   logic tb_prev_q;
   logic [15:0] db_prev_q, db_out_q;
   logic [7:0] cnt_q [16];

   // request decode
   wire [5:0] grp = reg_req.addr[7:2];
   wire [1:0] prt = reg_req.addr[1:0];
   wire req_ok = ce && !rst;
   wire wr_en = req_ok && reg_req.wr && prt != 2'h3;
   wire ack_in = req_ok && reg_req.rd_ack && grp == `GX_GRP_INPUT;

   // timebase pin qualifies debouncers only while it is an input
   wire tb_ok = cfg_q[`GX_TIMEBASE_BIT];
   wire tb_s = sync2_q[`GX_TIMEBASE_BIT];
   wire tick = tb_ok && tb_s && !tb_prev_q;

   // debounced level replaces the raw one on qualified pins
   wire [15:0] db_use = db_en_q & cfg_q[15:0] & {16{tb_ok}};
   wire [23:0] cur = {sync2_q[23:16],
      (db_use & db_out_q) | (~db_use & sync2_q[15:0])};

   // latched pins report the captured level until read
   wire [23:0] in_val = (lat_q & latf_q & latv_q) |
      ~(lat_q & latf_q) & cur;
   wire [23:0] diff = (cur ^ snap_q) & cfg_q;
   // a flag latched before a pin turned output must not keep the line low
   wire [23:0] irq_vec = ((lat_q & latf_q) | (~lat_q & diff)) &
      cfg_q;

   // pad controls, input pins never drive
   wire [23:0] pu_d = pen_q & psel_q;
   wire [23:0] pd_d = pen_q & ~psel_q;

   // read data select
   logic [7:0] rd_d;
   always_comb begin
      rd_d = 8'h00;
      case (grp)
         `GX_GRP_INPUT: rd_d = in_val[prt*8 +: 8];
         `GX_GRP_OUTPUT: rd_d = out_q[prt*8 +: 8];
         `GX_GRP_CONFIG: rd_d = cfg_q[prt*8 +: 8];
         `GX_GRP_PULL_EN: rd_d = pen_q[prt*8 +: 8];
         `GX_GRP_PULL_SEL: rd_d = psel_q[prt*8 +: 8];
         `GX_GRP_LATCH: rd_d = lat_q[prt*8 +: 8];
         default: rd_d = 8'h00;
      endcase
      if (prt == 2'h3) begin
         rd_d = 8'h00;
      end
      if (reg_req.addr == `GX_DB_EN0_ADDR) begin
         rd_d = db_en_q[7:0];
      end
      if (reg_req.addr == `GX_DB_EN1_ADDR) begin
         rd_d = db_en_q[15:8];
      end
      if (reg_req.addr == `GX_DB_CNT_ADDR) begin
         rd_d = db_cnt_q;
      end
   end

   // port registers, defaults under reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         out_q <= {3{`GX_OUTPUT_RST}};
         cfg_q <= {3{`GX_CONFIG_RST}};
         pen_q <= {3{`GX_PULL_EN_RST}};
         psel_q <= {3{`GX_PULL_SEL_RST}};
         lat_q <= {3{`GX_LATCH_RST}};
      end else if (wr_en) begin
         case (grp)
            `GX_GRP_OUTPUT: out_q[prt*8 +: 8] <= reg_req.wdata;
            `GX_GRP_CONFIG: cfg_q[prt*8 +: 8] <= reg_req.wdata;
            `GX_GRP_PULL_EN: pen_q[prt*8 +: 8] <= reg_req.wdata;
            `GX_GRP_PULL_SEL: psel_q[prt*8 +: 8] <= reg_req.wdata;
            `GX_GRP_LATCH: lat_q[prt*8 +: 8] <= reg_req.wdata;
            default: ;
         endcase
      end
   end

   // debounce registers, written by the host
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         db_en_q <= {2{`GX_DB_EN_RST}};
         db_cnt_q <= `GX_DB_CNT_RST;
      end else if (req_ok && reg_req.wr) begin
         if (reg_req.addr == `GX_DB_EN0_ADDR) begin
            db_en_q[7:0] <= reg_req.wdata;
         end
         if (reg_req.addr == `GX_DB_EN1_ADDR) begin
            db_en_q[15:8] <= reg_req.wdata;
         end
         if (reg_req.addr == `GX_DB_CNT_ADDR) begin
            db_cnt_q <= reg_req.wdata;
         end
      end
   end

   // pin synchronisers; first stage feeds only the second
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_q <= 24'h000000;
         sync2_q <= 24'h000000;
         tb_prev_q <= 1'b0;
      end else if (ce) begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         tb_prev_q <= tb_s;
      end
   end

   // per-pin debouncers, one shared tick and count
   genvar g;
   generate
      for (g = 0; g < `GX_NDB; g = g + 1) begin : g_db
         wire moved = sync2_q[g] != db_prev_q[g];
         wire done = cnt_q[g] == db_cnt_q;
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               db_prev_q[g] <= 1'b0;
               cnt_q[g] <= 8'h00;
               db_out_q[g] <= 1'b0;
            end else if (ce) begin
               db_prev_q[g] <= sync2_q[g];
               if (moved) begin
                  cnt_q[g] <= 8'h00;
               end else if (tick && !done) begin
                  cnt_q[g] <= cnt_q[g] + 8'h01;
               end
               // output only moves once the count is reached
               if (!moved && done) begin
                  db_out_q[g] <= db_prev_q[g];
               end
            end
         end
      end
   endgenerate

   // reference snapshot and latch capture; the read acknowledge
   // re-arms detection, a change in that very cycle may be absorbed
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         snap_q <= 24'h000000;
         latv_q <= 24'h000000;
         latf_q <= 24'h000000;
      end else if (ce) begin
         for (int p = 0; p < `GX_NPORT; p++) begin
            if (ack_in && prt == p[1:0]) begin
               snap_q[p*8 +: 8] <= cur[p*8 +: 8];
               latf_q[p*8 +: 8] <= 8'h00;
            end else begin
               for (int b = 0; b < 8; b++) begin
                  if (diff[p*8+b] && !latf_q[p*8+b]) begin
                     latf_q[p*8+b] <= 1'b1;
                     latv_q[p*8+b] <= cur[p*8+b];
                  end
               end
            end
         end
      end
   end

   // registered outputs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         drv_q <= '0;
         int_oe_q <= 1'b0;
         int_out_q <= 1'b0;
         rdata_q <= 8'h00;
      end else if (ce) begin
         drv_q.drive <= out_q & ~cfg_q;
         drv_q.oe <= ~cfg_q;
         drv_q.pull_up <= pu_d;
         drv_q.pull_dn <= pd_d;
         drv_q.in_buf_en <= cfg_q;
         int_oe_q <= |irq_vec;
         if (reg_req.rd && !rst) begin
            rdata_q <= rd_d;
         end
      end
   end

   assign pin_drv = drv_q;
   assign int_n_oe = int_oe_q;
   assign int_n_out = int_out_q;
   assign reg_rdata = rdata_q;

   // checks
   sequence s_bounce;
      ce && (sync2_q[0] != db_prev_q[0]);
   endsequence
   sequence s_settle;
      ce && (sync2_q[0] == db_prev_q[0]) && (cnt_q[0] == db_cnt_q);
   endsequence

   property p_in_no_drive;
      @(posedge ref_clk) disable iff (rst)
      ce |=> (drv_q.oe & $past(cfg_q)) == 24'h000000;
   endproperty
   a_in_no_drive: assert property (p_in_no_drive)
      else $error("input pin is driven");

   property p_out_level;
      @(posedge ref_clk) disable iff (rst)
      ce |=> ((drv_q.drive ^ $past(out_q)) & drv_q.oe) == 24'h000000;
   endproperty
   a_out_level: assert property (p_out_level)
      else $error("output level differs from output register");

   property p_pull_excl;
      @(posedge ref_clk) disable iff (rst)
      (drv_q.pull_up & drv_q.pull_dn) == 24'h000000;
   endproperty
   a_pull_excl: assert property (p_pull_excl)
      else $error("pull-up and pull-down both on");

   property p_out_no_irq;
      @(posedge ref_clk) disable iff (rst)
      ce && (cfg_q & ((lat_q & latf_q) | diff)) == 24'h000000 |=>
         !int_n_oe;
   endproperty
   a_out_no_irq: assert property (p_out_no_irq)
      else $error("output pin raised an interrupt");

   property p_irq_pin;
      @(posedge ref_clk) disable iff (rst)
      ce && (|irq_vec) |=> int_n_oe;
   endproperty
   a_irq_pin: assert property (p_irq_pin)
      else $error("pending change not shown on interrupt");

   property p_ack_clear;
      @(posedge ref_clk) disable iff (rst)
      ce && ack_in && prt == 2'h0 |=>
         snap_q[7:0] == $past(cur[7:0]) && latf_q[7:0] == 8'h00;
   endproperty
   a_ack_clear: assert property (p_ack_clear)
      else $error("read acknowledge did not clear port 0");

   property p_restart;
      @(posedge ref_clk) disable iff (rst)
      s_bounce |=> cnt_q[0] == 8'h00;
   endproperty
   a_restart: assert property (p_restart)
      else $error("debounce counter not restarted on edge");

   property p_hold;
      @(posedge ref_clk) disable iff (rst)
      ce && !$stable(db_out_q[0]) |-> $past(cnt_q[0]) == $past(db_cnt_q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("debounced output moved before qualification");

   property p_capture;
      @(posedge ref_clk) disable iff (rst)
      s_settle |=> db_out_q[0] == $past(db_prev_q[0]);
   endproperty
   a_capture: assert property (p_capture)
      else $error("qualified level not captured");

   property p_no_tb;
      @(posedge ref_clk) disable iff (rst)
      !tb_ok |-> cur == sync2_q;
   endproperty
   a_no_tb: assert property (p_no_tb)
      else $error("debouncer connected without timebase input");
endmodule

/* File: verif/reg_host.sv */
// far-side register master model: write, read and read-acknowledge strobes
// assumes ref_clk is shared with the pin logic; one request at a time
`timescale 1ns/1ps
module reg_host (
   // clock
   input wire logic ref_clk,
   // register port
   output gpio_expander_pkg::reg_req_type reg_req,
   input wire logic [7:0] reg_rdata
);
   initial reg_req = '0;

   // one-cycle write strobe, raised 1 ns after an edge
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1 reg_req = '{wr: 1'b1, rd: 1'b0, rd_ack: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      #1 reg_req = '0;
   endtask

   // read byte, then the acknowledge strobe that closes it
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      #1 reg_req = '{wr: 1'b0, rd: 1'b1, rd_ack: 1'b0, addr: a, wdata: 8'h00};
      @(posedge ref_clk);
      #1 d = reg_rdata;
      reg_req.rd = 1'b0;
      reg_req.rd_ack = 1'b1;
      @(posedge ref_clk);
      #1 reg_req = '0;
   endtask
endmodule

/* File: verif/tb.sv */
// self-checking bench of the expander pin logic
// assumes reg_host as register master; pin 16 carries the debounce timebase
`timescale 1ns/1ps
module tb;
   logic ref_clk;
   logic rst;
   logic ce;
   logic osc_on;
   logic osc;
   logic [23:0] pins;
   logic [7:0] rd_data;
   int fail_count;
   int n_checks;
   gpio_expander_pkg::reg_req_type reg_req;
   gpio_expander_pkg::pin_drive_type pin_drv;
   logic [7:0] reg_rdata;
   logic int_n_out;
   logic int_n_oe;
   // timebase replaces the bench level on pin 16
   wire [23:0] pin_in = {pins[23:17], osc, pins[15:0]};
   // open-drain line with its pull-up
   wire int_line = int_n_oe ? int_n_out : 1'b1;

   gpio_expander_port dut (
      .ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_drv(pin_drv),
      .int_n_out(int_n_out), .int_n_oe(int_n_oe));
   reg_host host (.ref_clk(ref_clk), .reg_req(reg_req),
      .reg_rdata(reg_rdata));

   // 10 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // 800 ns timebase, phase unrelated, parked low while unused
   initial begin
      osc = 1'b0;
      #137;
      forever #400 osc = osc_on ? ~osc : 1'b0;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic chk_pad(input string what, input logic [23:0] exp,
                          input logic [23:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h got %h", what, exp, got);
      end
   endtask

   // read a register and compare the byte
   task automatic reg_is(input logic [7:0] a, input logic [7:0] exp);
      host.read(a, rd_data);
      n_checks++;
      if (rd_data !== exp) begin
         fail_count++;
         $display("ERROR reg %h expected %h got %h", a, exp, rd_data);
      end
   endtask

   task automatic finish_test();
      if (fail_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // defaults after reset, unmapped place ignored
   task automatic t_reset();
      logic [7:0] a[9] = '{8'h6D, 8'h6E, 8'h6F, 8'h04, 8'h08, 8'h0C, 8'h10,
                           8'h14, 8'h03};
      logic [7:0] v[9] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF,
                           8'h00, 8'h00};
      chk_pad("oe", 24'h000000, pin_drv.oe);
      chk_pad("pull", 24'h000000, pin_drv.pull_up | pin_drv.pull_dn);
      chk_pad("inbuf", 24'hFFFFFF, pin_drv.in_buf_en);
      host.write(8'h03, 8'hAA);
      for (int i = 0; i < 9; i++) reg_is(a[i], v[i]);
      chk_pad("int", 24'h1, 24'(int_line));
   endtask

   // output drive, no interrupt, then back to input
   task automatic t_output();
      host.write(8'h04, 8'hA5);
      host.write(8'h08, 8'h00);
      cyc(2);
      chk_pad("oe", 24'h0000FF, pin_drv.oe);
      chk_pad("drive", 24'h0000A5, pin_drv.drive);
      chk_pad("inbuf", 24'hFFFF00, pin_drv.in_buf_en);
      pins[7:0] = 8'h3C;
      cyc(6);
      chk_pad("int", 24'h1, 24'(int_line));
      host.write(8'h08, 8'hFF);
      cyc(6);
      chk_pad("int", 24'h0, 24'(int_line));
      reg_is(8'h00, 8'h3C);
      cyc(2);
      chk_pad("int", 24'h1, 24'(int_line));
      pins[7:0] = 8'h00;
      cyc(6);
      chk_pad("int", 24'h0, 24'(int_line));
      reg_is(8'h00, 8'h00);
   endtask

   task automatic t_pull();
      host.write(8'h0D, 8'hFF);
      host.write(8'h11, 8'h0F);
      cyc(2);
      chk_pad("pullup", 24'h000F00, pin_drv.pull_up);
      chk_pad("pulldn", 24'h00F000, pin_drv.pull_dn);
   endtask

   // unlatched change: clear on return and on read
   task automatic t_int();
      pins[20] = 1'b1;
      cyc(4);
      chk_pad("int", 24'h0, 24'(int_line));
      pins[20] = 1'b0;
      cyc(4);
      chk_pad("int", 24'h1, 24'(int_line));
      pins[20] = 1'b1;
      cyc(4);
      reg_is(8'h02, 8'h10);
      cyc(2);
      chk_pad("int", 24'h1, 24'(int_line));
      pins[20] = 1'b0;
      cyc(4);
      chk_pad("int", 24'h0, 24'(int_line));
      reg_is(8'h02, 8'h00);
   endtask

   // latched pulse holds interrupt and level until read
   task automatic t_latch();
      host.write(8'h16, 8'hFF);
      pins[21] = 1'b1;
      cyc(4);
      pins[21] = 1'b0;
      cyc(6);
      chk_pad("int", 24'h0, 24'(int_line));
      reg_is(8'h02, 8'h20);
      cyc(2);
      chk_pad("int", 24'h1, 24'(int_line));
      host.write(8'h16, 8'h00);
   endtask

   // clock enable low: requests ignored and pin sampling frozen
   task automatic t_freeze();
      ce = 1'b0;
      host.write(8'h05, 8'h5A);
      pins[22] = 1'b1;
      cyc(6);
      chk_pad("int", 24'h1, 24'(int_line));
      ce = 1'b1;
      reg_is(8'h05, 8'hFF);
      cyc(2);
      chk_pad("int", 24'h0, 24'(int_line));
      pins[22] = 1'b0;
      cyc(4);
      chk_pad("int", 24'h1, 24'(int_line));
   endtask

   // count 3 at 800 ns: pin 0 and pin 15 debounced, pin 1 raw
   task automatic t_debounce();
      osc_on = 1'b1;
      host.write(8'h6F, 8'h03);
      host.write(8'h6D, 8'h01);
      host.write(8'h6E, 8'h80);
      pins[0] = 1'b1;
      cyc(3);
      reg_is(8'h00, 8'h00);
      pins[0] = 1'b0;
      cyc(40);
      reg_is(8'h00, 8'h00);
      pins[1:0] = 2'b11;
      cyc(10);
      reg_is(8'h00, 8'h02);
      for (int i = 0; i < 5; i++) begin
         pins[15] = ~pins[15];
         cyc(5);
      end
      reg_is(8'h00, 8'h03);
      reg_is(8'h01, 8'h00);
      // timebase pin made an output: pins fall back to raw levels
      host.write(8'h0A, 8'hFE);
      pins[0] = 1'b0;
      cyc(4);
      reg_is(8'h00, 8'h02);
      host.write(8'h0A, 8'hFF);
      osc_on = 1'b0;
   endtask

   // reset is held 20 cycles; a write inside it must be ignored
   initial begin
      rst = 1'b1;
      pins = '0;
      ce = 1'b1;
      osc_on = 1'b0;
      fail_count = 0;
      n_checks = 0;
      cyc(10);
      host.write(8'h04, 8'h00);
      cyc(8);
      rst = 1'b0;
      cyc(2);
      t_reset();
      t_output();
      t_pull();
      t_int();
      t_latch();
      t_freeze();
      t_debounce();
      finish_test();
   end

   // hang guard, well beyond the few hundred cycles the tests need
   initial begin
      #200000;
      fail_count++;
      finish_test();
   end
endmodule
